/* rtl/usb_test_regs_params.svh */
// Register offsets, field positions, reset values and pattern constants of the test register bank.
`ifndef USB_TEST_REGS_PARAMS_SVH
`define USB_TEST_REGS_PARAMS_SVH

`define FRAME_COUNT_OFFSET      12'h074
`define FIRMWARE_SCRATCH_OFFSET 12'h078
`define LINE_TEST_OFFSET        12'h084
`define LINE_TEST_ACCESS_OFFSET 12'h088

`define FRAME_COUNT_RESET       16'h0000
`define SCRATCH_RESET           16'h0000
`define LINE_TEST_RESET         8'h00

`define MICROFRAME_MSB          13
`define MICROFRAME_LSB          11
`define FRAME_INDEX_MSB         10
`define FRAME_INDEX_LSB         0

`define FORCE_HS_BIT            7
`define FORCE_FS_BIT            4
`define RANDOM_PATTERN_BIT      3
`define DRIVE_K_BIT             2
`define DRIVE_J_BIT             1
`define QUIESCENT_NAK_BIT       0
`define LINE_TEST_WRITE_MASK    8'h9f

`define RANDOM_LINE_PATTERN_SEED               9'h1ff

`endif

/* rtl/usb_test_regs_pkg.sv */
// Types shared by the frame, scratch and line test register bank.
package usb_test_regs_pkg;
  // Line state driven onto the USB pair during test: dp is bit 1, dm is bit 0.
  typedef logic [1:0] line_pair_t;
  typedef enum logic [3:0] {
    LINE_NORMAL  = 4'b0001,
    LINE_RANDOM  = 4'b0010,
    LINE_K       = 4'b0100,
    LINE_J       = 4'b1000
  } line_mode_e;
endpackage

/* rtl/usb_frame_scratch_test_regs.sv */
// Frame number capture, firmware scratch and line test mode registers behind APB.
`timescale 1ns/1ns
`include "usb_test_regs_params.svh"

//Contract
//- Frame register is read-only and captures each valid SOF frame number, except one that comes in a bus reset cycle.
//- Byte reads of the frame register give low byte first, then high.
//- Microframe sits in bits 13:11, frame in 10:0, bits 15:14 reserved.
//- Frame register clears on power-on reset and on USB bus reset.
//- A 16-bit read/write scratch register is free for firmware use.
//- Scratch high byte 15:8, low byte 7:0, both cleared by either reset.
//- One-byte read/write line test register, cleared by either reset.
//- Bit 7 forces high-speed only and disables chirp detection.
//- Bit 4 forces full-speed only and disables chirp detection.
//- Bit 3 toggles the line pair continuously in a pseudo-random pattern.
//- Bit 2 drives the line pair steadily to the K state.
//- Bit 1 drives the line pair steadily to the J state.
//- Bit 0 holds high-speed quiescent and answers valid HS IN tokens with NAK.
module usb_frame_scratch_test_regs
  import usb_test_regs_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
) (
  // Clock and reset.
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  // USB bus reset, SOF capture and HS IN token from the protocol engine.
  input  wire logic                  bus_reset_in,
  input  wire logic                  sof_valid_in,
  input  wire logic [2:0]            sof_microframe_in,
  input  wire logic [10:0]           sof_frame_in,
  input  wire logic                  hs_in_token_in,
  // APB slave.
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [ADDR_WIDTH-1:0] paddr_in,
  input  wire logic [31:0]           pwdata_in,
  input  wire logic [3:0]            pstrb_in,
  output logic                       pready_out,
  output logic                       pslverr_out,
  output logic [31:0]                prdata_out,
  // Test controls toward the physical layer.
  output logic                       force_high_speed_out,
  output logic                       force_full_speed_out,
  output logic                       chirp_disable_out,
  output logic                       quiescent_out,
  output logic                       nak_in_token_out,
  output logic                       line_drive_en_out,
  output line_pair_t                 line_pair_out
);

  logic [15:0] frame_count_capture_reg;
  logic [15:0] frame_count_capture_next;
  logic [15:0] firmware_scratch_reg;
  logic [15:0] firmware_scratch_next;
  logic [7:0]  line_test_control_reg;
  logic [7:0]  line_test_control_next;
  logic        frame_byte_hi_reg;
  logic        frame_byte_hi_next;
  logic [8:0]  random_line_pattern_reg;
  logic [8:0]  random_line_pattern_next;
  logic [31:0] prdata_next;
  logic        pready_next;
  logic        pslverr_next;
  line_mode_e  line_mode;
  line_pair_t  line_pair_next;

  wire clear_all  = bus_reset_in;
  wire setup      = psel_in && !penable_in;
  wire access     = psel_in && penable_in && pready_out;
  wire wr_access  = access && pwrite_in;
  wire rd_setup   = setup && !pwrite_in;
  wire hit_frame  = paddr_in == ADDR_WIDTH'(`FRAME_COUNT_OFFSET);
  wire hit_scr    = paddr_in == ADDR_WIDTH'(`FIRMWARE_SCRATCH_OFFSET);
  wire hit_test   = paddr_in == ADDR_WIDTH'(`LINE_TEST_OFFSET);
  wire hit_byte   = paddr_in == ADDR_WIDTH'(`LINE_TEST_ACCESS_OFFSET);
  wire hit_any    = hit_frame || hit_scr || hit_test || hit_byte;
  wire wr_scr     = wr_access && hit_scr;
  wire wr_test    = wr_access && hit_test && pstrb_in[0];
  // A byte read of the frame register alternates low byte, then high byte.
  wire byte_read  = access && !pwrite_in && hit_byte;

  wire [15:0] frame_value = {2'b00, sof_microframe_in, sof_frame_in};
  wire [7:0]  line_test_wdata = pwdata_in[7:0] & `LINE_TEST_WRITE_MASK;

  wire t_hs  = line_test_control_reg[`FORCE_HS_BIT];
  wire t_fs  = line_test_control_reg[`FORCE_FS_BIT];
  wire t_rnd = line_test_control_reg[`RANDOM_PATTERN_BIT];
  wire t_k   = line_test_control_reg[`DRIVE_K_BIT];
  wire t_j   = line_test_control_reg[`DRIVE_J_BIT];
  wire t_q   = line_test_control_reg[`QUIESCENT_NAK_BIT];

  // Frame capture, cleared by bus reset and ignoring any bus write.
  always_comb begin
    frame_count_capture_next = frame_count_capture_reg;
    if (clear_all) begin
      frame_count_capture_next = `FRAME_COUNT_RESET;
    end else if (sof_valid_in) begin
      frame_count_capture_next = frame_value;
    end
  end

  always_comb begin
    firmware_scratch_next = firmware_scratch_reg;
    if (clear_all) begin
      firmware_scratch_next = `SCRATCH_RESET;
    end else if (wr_scr) begin
      if (pstrb_in[1]) begin
        firmware_scratch_next[15:8] = pwdata_in[15:8];
      end
      if (pstrb_in[0]) begin
        firmware_scratch_next[7:0] = pwdata_in[7:0];
      end
    end
  end

  always_comb begin
    line_test_control_next = line_test_control_reg;
    if (clear_all) begin
      line_test_control_next = `LINE_TEST_RESET;
    end else if (wr_test) begin
      line_test_control_next = line_test_wdata;
    end
  end

  always_comb begin
    frame_byte_hi_next = frame_byte_hi_reg;
    if (clear_all) begin
      frame_byte_hi_next = 1'b0;
    end else if (byte_read) begin
      frame_byte_hi_next = !frame_byte_hi_reg;
    end
  end

  // Read data is prepared in the setup cycle and held through the access phase.
  always_comb begin
    prdata_next = prdata_out;
    if (rd_setup) begin
      prdata_next = 32'h0000_0000;
      if (hit_frame) begin
        prdata_next = {16'h0000, 2'b00, frame_count_capture_reg[13:0]};
      end else if (hit_scr) begin
        prdata_next = {16'h0000, firmware_scratch_reg};
      end else if (hit_test) begin
        prdata_next = {24'h00_0000, line_test_control_reg};
      end else if (hit_byte) begin
        prdata_next = {24'h00_0000, frame_byte_hi_reg ?
                       {2'b00, frame_count_capture_reg[13:8]} :
                       frame_count_capture_reg[7:0]};
      end
    end
  end

  assign pready_next  = setup;
  assign pslverr_next = setup && !hit_any;

  // Pseudo-random line toggling from a 9-bit LFSR.
  assign random_line_pattern_next = t_rnd ? {random_line_pattern_reg[7:0], random_line_pattern_reg[8] ^ random_line_pattern_reg[4]} : `RANDOM_LINE_PATTERN_SEED;

  assign line_mode = t_rnd ? LINE_RANDOM :
                     t_k   ? LINE_K :
                     t_j   ? LINE_J : LINE_NORMAL;

  always_comb begin
    line_pair_next = 2'b00;
    unique case (line_mode)
      LINE_NORMAL: line_pair_next = 2'b00;
      LINE_RANDOM: line_pair_next = {random_line_pattern_reg[8], !random_line_pattern_reg[8]};
      LINE_K:      line_pair_next = 2'b01;
      LINE_J:      line_pair_next = 2'b10;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      frame_count_capture_reg <= `FRAME_COUNT_RESET;
      firmware_scratch_reg    <= `SCRATCH_RESET;
      line_test_control_reg   <= `LINE_TEST_RESET;
      frame_byte_hi_reg       <= 1'b0;
      random_line_pattern_reg                <= `RANDOM_LINE_PATTERN_SEED;
    end else begin
      frame_count_capture_reg <= frame_count_capture_next;
      firmware_scratch_reg    <= firmware_scratch_next;
      line_test_control_reg   <= line_test_control_next;
      frame_byte_hi_reg       <= frame_byte_hi_next;
      random_line_pattern_reg                <= random_line_pattern_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= pready_next;
      pslverr_out <= pslverr_next;
      prdata_out  <= prdata_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      force_high_speed_out <= 1'b0;
      force_full_speed_out <= 1'b0;
      chirp_disable_out    <= 1'b0;
      quiescent_out        <= 1'b0;
      nak_in_token_out     <= 1'b0;
      line_drive_en_out    <= 1'b0;
      line_pair_out        <= 2'b00;
    end else begin
      force_high_speed_out <= t_hs;
      force_full_speed_out <= t_fs;
      chirp_disable_out    <= t_hs || t_fs;
      quiescent_out        <= t_q;
      nak_in_token_out     <= t_q && hs_in_token_in;
      line_drive_en_out    <= t_rnd || t_k || t_j || t_q;
      line_pair_out        <= line_pair_next;
    end
  end

  chk_frame_capture: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    sof_valid_in && !bus_reset_in |=> frame_count_capture_reg == $past(frame_value))
    else $error("frame capture missed a valid SOF");

  chk_frame_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !sof_valid_in && !bus_reset_in |=> $stable(frame_count_capture_reg))
    else $error("frame register changed without SOF");

  chk_frame_reserved: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    frame_count_capture_reg[15:14] == 2'b00)
    else $error("frame reserved bits set");

  chk_bus_reset_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    bus_reset_in |=> frame_count_capture_reg == 16'h0000 && firmware_scratch_reg == 16'h0000
    && line_test_control_reg == 8'h00)
    else $error("bus reset did not clear registers");

  chk_scratch_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_scr && !bus_reset_in && pstrb_in[1:0] == 2'b11
    |=> firmware_scratch_reg == $past(pwdata_in[15:0]))
    else $error("scratch write lost");

  chk_byte_order: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    byte_read && !frame_byte_hi_reg && !bus_reset_in |=> frame_byte_hi_reg)
    else $error("frame byte order did not advance");

  chk_test_mask: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    line_test_control_reg[6:5] == 2'b00)
    else $error("line test reserved bits set");

  chk_chirp_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (t_hs || t_fs) |=> chirp_disable_out)
    else $error("chirp not disabled under forced speed");

  chk_k_state: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    t_k && !t_rnd ##1 t_k |-> line_pair_out == 2'b01 && line_drive_en_out)
    else $error("K state not driven");

  chk_j_state: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    t_j && !t_rnd && !t_k ##1 t_j && !t_k && !t_rnd |-> line_pair_out == 2'b10)
    else $error("J state not driven");

  chk_random_toggle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    t_rnd[*8] |-> line_pair_out != 2'b00 && line_pair_out != 2'b11)
    else $error("random pattern not differential");

  chk_quiescent_nak: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    t_q && hs_in_token_in |=> nak_in_token_out && quiescent_out)
    else $error("quiescent NAK missing");

  // The checks below pin down holding, partial writes, read data and idle outputs.
  chk_scratch_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !wr_scr && !bus_reset_in |=> $stable(firmware_scratch_reg))
    else $error("scratch changed without a write");

  chk_scratch_low_only: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_scr && !bus_reset_in && pstrb_in[1:0] == 2'b01 |=> firmware_scratch_reg ==
    {$past(firmware_scratch_reg[15:8]), $past(pwdata_in[7:0])})
    else $error("scratch low byte write disturbed the high byte");

  chk_test_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wr_test && !bus_reset_in
    |=> line_test_control_reg == ($past(pwdata_in[7:0]) & `LINE_TEST_WRITE_MASK))
    else $error("line test write lost");

  chk_test_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !wr_test && !bus_reset_in |=> $stable(line_test_control_reg))
    else $error("line test register changed without a write");

  chk_force_hs: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    t_hs |=> force_high_speed_out)
    else $error("forced high speed not signalled");

  chk_force_fs: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    t_fs |=> force_full_speed_out)
    else $error("forced full speed not signalled");

  chk_chirp_on: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !t_hs && !t_fs |=> !chirp_disable_out)
    else $error("chirp disabled without a forced speed");

  chk_byte_order_back: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    byte_read && frame_byte_hi_reg && !bus_reset_in |=> !frame_byte_hi_reg)
    else $error("frame byte order did not return to the low byte");

  chk_byte_low_data: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rd_setup && hit_byte && !frame_byte_hi_reg
    |=> prdata_out == {24'h00_0000, $past(frame_count_capture_reg[7:0])})
    else $error("frame low byte read wrong");

  chk_frame_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    rd_setup && hit_frame
    |=> prdata_out == {18'h0_0000, $past(frame_count_capture_reg[13:0])})
    else $error("frame register read wrong");

  chk_bus_reset_ptr: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    bus_reset_in |=> !frame_byte_hi_reg)
    else $error("bus reset did not clear the byte order");

  chk_nak_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !t_q |=> !nak_in_token_out)
    else $error("NAK outside quiescent test");

  chk_line_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !t_rnd && !t_k && !t_j && !t_q |=> !line_drive_en_out && line_pair_out == 2'b00)
    else $error("line pair driven with no test bit set");

  chk_random_rest: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !t_rnd |=> random_line_pattern_reg == `RANDOM_LINE_PATTERN_SEED)
    else $error("pattern generator not parked at its seed");

  chk_k_level_drive: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    t_k && !t_rnd |=> line_drive_en_out && line_pair_out == 2'b01)
    else $error("K level not driven");

  chk_quiescent_level: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    t_q |=> quiescent_out && line_drive_en_out)
    else $error("quiescent state not held");

endmodule

/* sim/usb_engine_model.sv */
// Protocol engine model that reports received SOFs and HS IN tokens.
`timescale 1ns/1ns
module usb_engine_model (
  // Clock.
  input  wire logic   clk_in,
  // Engine reports.
  output logic        sof_valid_out,
  output logic [2:0]  sof_microframe_out,
  output logic [10:0] sof_frame_out,
  output logic        hs_in_token_out
);
  initial begin
    sof_valid_out = 1'b0;
    sof_microframe_out = 3'h0;
    sof_frame_out = 11'h000;
    hs_in_token_out = 1'b0;
  end
  // The values are inverted after the pulse so that a late capture shows.
  task automatic send_sof(input logic [2:0] mf, input logic [10:0] fr);
    @(posedge clk_in);
    sof_valid_out <= 1'b1;
    sof_microframe_out <= mf;
    sof_frame_out <= fr;
    @(posedge clk_in);
    sof_valid_out <= 1'b0;
    sof_microframe_out <= ~mf;
    sof_frame_out <= ~fr;
  endtask
  task automatic in_token();
    @(posedge clk_in);
    hs_in_token_out <= 1'b1;
    @(posedge clk_in);
    hs_in_token_out <= 1'b0;
  endtask
endmodule

/* sim/tb_top.sv */
// Self-checking testbench of the frame, scratch and line test register bank.
`timescale 1ns/1ns
`include "usb_test_regs_params.svh"
module tb_top;
  import usb_test_regs_pkg::*;
  logic        clk_in, rst_n_in, bus_reset_in, sof_valid_in, hs_in_token_in;
  logic [2:0]  sof_microframe_in;
  logic [10:0] sof_frame_in;
  logic        psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out;
  logic [3:0]  pstrb_in;
  logic        force_high_speed_out, force_full_speed_out, chirp_disable_out;
  logic        quiescent_out, nak_in_token_out, line_drive_en_out, seen;
  line_pair_t  line_pair_out;
  int          n_fail, comparisons, cycles;
  logic [33:0] notes[$];
  logic [33:0] n;
  logic [15:0] scr;
  logic [13:0] frm;
  logic [6:0]  phy;
  int          bits[6] = '{7, 4, 3, 2, 1, 0};
  logic [6:0]  phy_exp[6] = '{7'h50, 7'h30, 7'h04, 7'h05, 7'h06, 7'h0c};

  usb_frame_scratch_test_regs dut (.clk_in, .rst_n_in, .bus_reset_in, .sof_valid_in,
    .sof_microframe_in, .sof_frame_in, .hs_in_token_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .pstrb_in, .pready_out, .pslverr_out, .prdata_out,
    .force_high_speed_out, .force_full_speed_out, .chirp_disable_out, .quiescent_out,
    .nak_in_token_out, .line_drive_en_out, .line_pair_out);
  usb_engine_model u_eng (.clk_in, .sof_valid_out(sof_valid_in),
    .sof_microframe_out(sof_microframe_in), .sof_frame_out(sof_frame_in),
    .hs_in_token_out(hs_in_token_in));

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic err, input logic [31:0] exp);
    notes.push_back({~w, err, exp});
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    pstrb_in <= s;
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    while (pready_out !== 1'b1) @(posedge clk_in);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0, 1'b0, exp);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, a, d, s, 1'b0, 32'h0);
  endtask

  // Each completed transfer is matched against the oldest note.
  always @(posedge clk_in) begin
    if (pready_out === 1'b1) begin
      n = notes.pop_front();
      chk({31'h0, pslverr_out}, {31'h0, n[32]});
      if (n[33]) chk(prdata_out, n[31:0]);
    end
  end
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      end_of_test();
    end
  end

  initial begin
    {rst_n_in, bus_reset_in, psel_in, penable_in, pwrite_in} = 5'h0;
    {paddr_in, pwdata_in, pstrb_in} = '0;
    void'($urandom(32'hb3fd78c4));
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(`FRAME_COUNT_OFFSET, 32'h0);
    rd(`FIRMWARE_SCRATCH_OFFSET, 32'h0);
    rd(`LINE_TEST_OFFSET, 32'h0);
    scr = $urandom();
    wr(`FIRMWARE_SCRATCH_OFFSET, {16'h0, scr}, 4'h3);
    rd(`FIRMWARE_SCRATCH_OFFSET, {16'h0, scr});
    wr(`FIRMWARE_SCRATCH_OFFSET, {16'h0, ~scr}, 4'h1);
    rd(`FIRMWARE_SCRATCH_OFFSET, {16'h0, scr[15:8], ~scr[7:0]});
    apb(1'b1, 12'h07c, 32'h0, 4'hf, 1'b1, 32'h0);
    for (int i = 0; i < 2; i++) begin
      frm = $urandom();
      u_eng.send_sof(frm[13:11], frm[10:0]);
      rd(`FRAME_COUNT_OFFSET, {18'h0, frm});
      wr(`FRAME_COUNT_OFFSET, 32'hffffffff, 4'hf);
      rd(`FRAME_COUNT_OFFSET, {18'h0, frm});
      rd(`LINE_TEST_ACCESS_OFFSET, {24'h0, frm[7:0]});
      rd(`LINE_TEST_ACCESS_OFFSET, {26'h0, frm[13:8]});
    end
    for (int i = 0; i < 6; i++) begin
      wr(`LINE_TEST_OFFSET, 32'h1 << bits[i], 4'h1);
      rd(`LINE_TEST_OFFSET, 32'h1 << bits[i]);
      repeat (3) @(posedge clk_in);
      phy = {force_high_speed_out, force_full_speed_out, chirp_disable_out, quiescent_out,
             line_drive_en_out, line_pair_out};
      chk(phy & (bits[i] == 3 ? 7'h7c : 7'h7f), phy_exp[i]);
      seen = 1'b0;
      repeat (16) begin
        @(posedge clk_in);
        if (line_pair_out !== phy[1:0] && line_pair_out !== 2'b00) seen = 1'b1;
      end
      chk(seen, bits[i] == 3);
      if (bits[i] == 0) begin
        u_eng.in_token();
        @(posedge clk_in);
        chk(nak_in_token_out, 1);
      end
    end
    wr(`LINE_TEST_OFFSET, 32'h60, 4'h1);
    rd(`LINE_TEST_OFFSET, 32'h0);
    wr(`FIRMWARE_SCRATCH_OFFSET, 32'ha5c3, 4'h3);
    wr(`LINE_TEST_OFFSET, 32'h02, 4'h1);
    @(posedge clk_in);
    bus_reset_in <= 1'b1;
    u_eng.send_sof(3'h5, 11'h2aa);
    bus_reset_in <= 1'b0;
    rd(`FRAME_COUNT_OFFSET, 32'h0);
    rd(`FIRMWARE_SCRATCH_OFFSET, 32'h0);
    rd(`LINE_TEST_OFFSET, 32'h0);
    rd(`LINE_TEST_ACCESS_OFFSET, 32'h0);
    chk({line_drive_en_out, line_pair_out}, 0);
    u_eng.in_token();
    @(posedge clk_in);
    chk(nak_in_token_out, 0);
    end_of_test();
  end
endmodule
